// File: esbc_bus_master.sv
// bus master model that drives the controller's request port
// assumes ref_clk from the bench; requests change just after falling edges
`timescale 1ns/1ps
`default_nettype none
module esbc_bus_master (
  // clock
  input wire logic ref_clk,
  // controller answer
  input wire logic ready,
  input wire logic [31:0] rdata,
  input wire logic bus_err,
  input wire esbc_pkg::esbc_err_t err_rpt,
  // request to the controller
  output esbc_pkg::esbc_req_t req
);
  // nothing requested at time zero
  initial req = '0;
  // raise a request and hold it until the answer
  task automatic put(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d);
    @(negedge ref_clk);
    req = {1'b1, w, sz, a, d};
  endtask : put
  // released fields flip so a stale value never passes for a live one
  task automatic drop();
    @(negedge ref_clk);
    req = {1'b0, ~req.write, ~req.size, ~req.addr, ~req.wdata};
  endtask : drop
  // whole transfer; n is the cycle count from the take edge to ready
  task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q, output logic be,
                      output logic ev, output int n);
    n = -1;
    ev = 1'b0;
    q = '0;
    be = 1'b0;
    put(w, sz, a, d);
    @(posedge ref_clk);
    // bounded wait; the longest legal answer is well inside this
    for (int i = 0; i < 24 && n < 0; i++) begin
      @(negedge ref_clk);
      ev = ev | err_rpt.valid;
      if (ready === 1'b1) begin
        n = i + 1;
        q = rdata;
        be = bus_err;
      end
    end
    // hold through the edge that samples ready; the caller's next put or drop
    // replaces the request at the following falling edge, so accesses run back
    // to back and the wait-state table sees the previous access
    @(posedge ref_clk);
  endtask : xfer
endmodule : esbc_bus_master
`default_nettype wire

// File: esbc_ctrl.sv
// ecc sram bus controller: bus slave, sec-ded code, read-modify-write, wait states
// assumes the bus master holds the request stable until ready, same clock domain
//
// Operation
// (R01) correct any single-bit error on reads
// (R02) flag double-bit errors as uncorrectable
// (R03) all-zero or all-one codeword raises error
// (R04) wider corruptions need not be flagged
// (R05) accept byte, halfword and word transfers
// (R06) full word write: no read, encode, store
// (R07) sub-word write reads and checks word first
// (R08) merge bytes, re-encode, write codeword back
// (R09) check in read phase, encode in write
// (R10) wait states from current and previous operation
// (R11) read waits: same-address after write zero
// (R12) sub-word after sub-word or word: two
// (R13) sub-word same address zero, idle/read one
// (R14) word write after idle/word/read: zero
// (R15) extra configurable wait states supported
// (R16) reset mid-access touches only that location
// (R17) reset while idle leaves array intact
// (R18) software reset only with no accesses
// (R19) master initialises with word writes first
// (R20) contiguous region at base, no registers
// (R21) fixed sec-ded code, report address, syndrome
// (R22) uncorrectable rmw read aborts, bus error
`timescale 1ns/1ps
`default_nettype none
module esbc_ctrl #(
  parameter int unsigned DEPTH = esbc_pkg::CAP_BYTES / 4,
  parameter int unsigned AW = $clog2(DEPTH),
  parameter logic [1:0] EXTRA_WS = 2'h0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bus request side
  input wire esbc_pkg::esbc_req_t req,
  output logic ready,
  output logic [31:0] rdata,
  output logic bus_err,
  // error report to external status block
  output esbc_pkg::esbc_err_t err_rpt
);
  // hamming position of data bit i, skipping powers of two (positions 1..38)
  function automatic logic [5:0] pos_of(input int i);
    int p;
    int k;
    p = 0;
    k = -1;
    for (int j = 1; j < 39; j++) begin
      if ((j & (j - 1)) != 0) begin
        k++;
        if (k == i) p = j;
      end
    end
    return p[5:0];
  endfunction : pos_of

  // seven check bits: six hamming bits plus overall parity (R21)
  function automatic logic [6:0] enc(input logic [31:0] d);
    logic [6:0] c;
    logic [5:0] p;
    c = 7'h00;
    for (int i = 0; i < 32; i++) begin
      p = pos_of(i);
      if (d[i]) c[5:0] = c[5:0] ^ p;
    end
    c[6] = ^d ^ ^c[5:0];
    // stored inverted by a fixed mask, so a blank or stuck word never decodes clean
    return c ^ esbc_pkg::CHECK_INV;
  endfunction : enc

  // storage array, flip-flops; only written from the merge/write phase
  logic [38:0] mem [DEPTH];
  // registered state
  esbc_pkg::esbc_state_t state, next_state;
  esbc_pkg::esbc_op_t prev_op, next_prev_op; // operation of the preceding clock
  logic [31:0] last_addr, next_last_addr; // address of last completed write
  logic [1:0] wcnt, next_wcnt; // remaining wait states
  logic [31:0] rdata_q, next_rdata;
  logic berr_q, next_berr;
  esbc_pkg::esbc_err_t err_q, next_err;
  logic [31:0] fixed, next_fixed; // corrected word held for merge
  logic [31:0] merged;

  // decode of the addressed word; array index from byte address (R20)
  logic [AW-1:0] idx;
  logic in_range;
  logic [38:0] code;
  logic [6:0] syn;
  logic [31:0] corr;
  logic sbe, dbe, stuck;
  logic is_word;
  logic [1:0] ws;
  assign idx = req.addr[AW+1:2];
  assign in_range = (req.addr - esbc_pkg::BASE_ADDR) < esbc_pkg::CAP_BYTES; // R20
  assign code = mem[idx];
  assign is_word = req.size == esbc_pkg::SIZE_WORD; // R05

  // check phase: syndrome and correction (R09)
  always_comb begin
    logic [6:0] c;
    c = enc(code[31:0]);
    // overall bit is the parity of all 39 stored bits with the mask removed; taking it
    // from freshly computed hamming bits would miss flips at odd-weight positions
    syn = {(^code) ^ (^esbc_pkg::CHECK_INV), c[5:0] ^ code[37:32]};
    corr = code[31:0];
    stuck = (code == esbc_pkg::CODE_ZERO) || (code == esbc_pkg::CODE_ONES); // R03
    sbe = syn[6]; // odd overall parity: one flipped bit R01
    dbe = !syn[6] && (syn[5:0] != 6'h00); // even parity, nonzero: two bits R02
    // bits beyond two may alias; no promise made there R04
    for (int i = 0; i < 32; i++) begin
      if (sbe && syn[5:0] == pos_of(i)) corr[i] = !corr[i]; // R01
    end
  end

  // byte-lane merge of write data into corrected word (R08)
  always_comb begin
    merged = fixed;
    if (req.size == esbc_pkg::SIZE_BYTE) begin
      merged[req.addr[1:0]*8 +: 8] = req.wdata[req.addr[1:0]*8 +: 8];
    end else begin
      merged[req.addr[1]*16 +: 16] = req.wdata[req.addr[1]*16 +: 16];
    end
  end

  // wait-state table from current and previous clock's operation (R10)
  always_comb begin
    logic same;
    same = req.addr[31:2] == last_addr[31:2];
    ws = esbc_pkg::WS_ONE;
    if (!req.write) begin
      case (prev_op)
        esbc_pkg::ESBC_OP_READ: ws = esbc_pkg::WS_ZERO; // pipelined read R11
        esbc_pkg::ESBC_OP_SUBW, esbc_pkg::ESBC_OP_WORD:
          ws = same ? esbc_pkg::WS_ZERO : esbc_pkg::WS_ONE; // R11
        default: ws = esbc_pkg::WS_ONE; // R11
      endcase
    end else if (is_word) begin
      ws = esbc_pkg::WS_ZERO; // R14
    end else begin
      case (prev_op)
        esbc_pkg::ESBC_OP_SUBW:
          ws = same ? esbc_pkg::WS_ZERO : esbc_pkg::WS_TWO; // R13 R12
        esbc_pkg::ESBC_OP_WORD: ws = esbc_pkg::WS_TWO; // R12
        default: ws = esbc_pkg::WS_ONE; // R13
      endcase
    end
    ws = ws + EXTRA_WS; // R15
  end

  // next-state logic
  always_comb begin
    next_state = state;
    next_prev_op = esbc_pkg::ESBC_OP_IDLE;
    next_last_addr = last_addr;
    next_wcnt = wcnt;
    next_rdata = rdata_q;
    next_berr = 1'b0;
    next_err = '0;
    next_fixed = fixed;
    ready = 1'b0;
    case (state)
      esbc_pkg::ESBC_ST_IDLE: begin
        if (req.valid) begin
          next_wcnt = ws;
          next_state = esbc_pkg::ESBC_ST_WAIT;
        end
      end
      esbc_pkg::ESBC_ST_WAIT: begin
        if (wcnt != 2'h0) begin
          next_wcnt = wcnt - 2'h1;
        end else if (!in_range) begin
          next_berr = 1'b1;
          next_state = esbc_pkg::ESBC_ST_DONE;
        end else if (req.write && is_word) begin
          next_state = esbc_pkg::ESBC_ST_DONE; // R06 no read
          next_prev_op = esbc_pkg::ESBC_OP_WORD;
          next_last_addr = req.addr;
        end else begin
          next_state = esbc_pkg::ESBC_ST_READ; // R07
        end
      end
      esbc_pkg::ESBC_ST_READ: begin
        if (stuck || dbe || sbe) begin
          next_err.valid = 1'b1; // R21
          next_err.uncorr = stuck || dbe;
          next_err.addr = req.addr;
          next_err.syndrome = syn;
        end
        next_fixed = corr;
        next_rdata = corr; // R01
        if (stuck || dbe) begin
          next_berr = 1'b1; // R02 R03 R22
          next_state = esbc_pkg::ESBC_ST_DONE;
        end else if (req.write) begin
          next_state = esbc_pkg::ESBC_ST_MERGE; // R07
        end else begin
          next_prev_op = esbc_pkg::ESBC_OP_READ;
          next_state = esbc_pkg::ESBC_ST_DONE;
        end
      end
      esbc_pkg::ESBC_ST_MERGE: begin
        next_prev_op = esbc_pkg::ESBC_OP_SUBW;
        next_last_addr = req.addr;
        next_state = esbc_pkg::ESBC_ST_DONE;
      end
      esbc_pkg::ESBC_ST_DONE: begin
        ready = 1'b1; // answer with data or error this cycle
        next_prev_op = prev_op;
        next_state = esbc_pkg::ESBC_ST_IDLE;
      end
      default: next_state = esbc_pkg::ESBC_ST_IDLE;
    endcase
  end

  // control registers; reset leaves the array alone (R17)
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= esbc_pkg::ESBC_ST_IDLE;
      prev_op <= esbc_pkg::ESBC_OP_IDLE;
      last_addr <= 32'h0000_0000;
      wcnt <= 2'h0;
      rdata_q <= 32'h0000_0000;
      berr_q <= 1'b0;
      err_q <= '0;
      fixed <= 32'h0000_0000;
    end else begin
      state <= next_state;
      prev_op <= next_prev_op;
      last_addr <= next_last_addr;
      wcnt <= next_wcnt;
      rdata_q <= next_rdata;
      berr_q <= next_berr;
      err_q <= next_err;
      fixed <= next_fixed;
    end
  end

  // array write: single word, single cycle, only the addressed index (R16)
  always_ff @(posedge ref_clk) begin
    if (state == esbc_pkg::ESBC_ST_MERGE) begin
      mem[idx] <= {enc(merged), merged}; // R08 R09
    end else if (state == esbc_pkg::ESBC_ST_WAIT && wcnt == 2'h0 && in_range
                 && req.write && is_word) begin
      mem[idx] <= {enc(req.wdata), req.wdata}; // R06
    end
  end

  assign rdata = rdata_q;
  assign bus_err = berr_q;
  assign err_rpt = err_q;

  // named steps of a sub-word write
  sequence s_rmw_start;
    state == esbc_pkg::ESBC_ST_READ && req.write && !dbe && !stuck;
  endsequence
  sequence s_rmw_done;
    state == esbc_pkg::ESBC_ST_MERGE ##1 ready;
  endsequence

  chk_rmw_order: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    s_rmw_start |=> s_rmw_done) else $error("rmw did not merge then answer");
  chk_uncorr_abort: assert property (@(posedge ref_clk) disable iff (!arst_n) // R22
    (state == esbc_pkg::ESBC_ST_READ && dbe) |=> (bus_err && ready))
    else $error("double error did not abort");
  chk_stuck_flag: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    (state == esbc_pkg::ESBC_ST_READ && stuck) |=> (err_rpt.valid && err_rpt.uncorr))
    else $error("stuck codeword not flagged");
  // an all-one word also shows odd parity; the stuck verdict wins there
  chk_single_fix: assert property (@(posedge ref_clk) disable iff (!arst_n) // R01
    (state == esbc_pkg::ESBC_ST_READ && sbe && !stuck && !req.write)
    |=> (!bus_err && err_rpt.valid && !err_rpt.uncorr))
    else $error("single error not corrected");
  chk_dbl_flag: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    (state == esbc_pkg::ESBC_ST_READ && dbe) |=> err_rpt.uncorr)
    else $error("double error not flagged");
  chk_word_noread: assert property (@(posedge ref_clk) disable iff (!arst_n) // R06
    (state == esbc_pkg::ESBC_ST_WAIT && wcnt == 2'h0 && in_range && req.write && is_word)
    |=> state == esbc_pkg::ESBC_ST_DONE) else $error("word write read the array");
  chk_wait_count: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
    (state == esbc_pkg::ESBC_ST_IDLE && req.valid) |=> wcnt == $past(ws))
    else $error("wait count not loaded");
  chk_subw_reads: assert property (@(posedge ref_clk) disable iff (!arst_n) // R07
    (state == esbc_pkg::ESBC_ST_WAIT && wcnt == 2'h0 && in_range && !is_word)
    |=> state == esbc_pkg::ESBC_ST_READ) else $error("sub-word skipped read");
  chk_word_zero_ws: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
    (state == esbc_pkg::ESBC_ST_IDLE && req.valid && req.write && is_word)
    |=> wcnt == EXTRA_WS) else $error("word write got waits");
  // table corners that back-to-back traffic reaches: pipelined read, sub-word after word
  chk_read_pipe: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
    (state == esbc_pkg::ESBC_ST_IDLE && req.valid && !req.write
     && prev_op == esbc_pkg::ESBC_OP_READ) |=> wcnt == EXTRA_WS)
    else $error("pipelined read got waits");
  chk_subw_after_word: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
    (state == esbc_pkg::ESBC_ST_IDLE && req.valid && req.write && !is_word
     && prev_op == esbc_pkg::ESBC_OP_WORD) |=> wcnt == esbc_pkg::WS_TWO + EXTRA_WS)
    else $error("sub-word after word not two waits");
  chk_range_refuse: assert property (@(posedge ref_clk) disable iff (!arst_n) // R20
    (state == esbc_pkg::ESBC_ST_WAIT && wcnt == 2'h0 && !in_range) |=> (bus_err && ready))
    else $error("out-of-range access not refused");
  chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
    ready |=> !ready) else $error("ready held past one cycle");
endmodule : esbc_ctrl
`default_nettype wire

// File: esbc_pkg.sv
// package for the ecc sram bus controller: geometry, codes, wait-state figures
// assumes a single 25 MHz bus clock and a flip-flop storage array
package esbc_pkg;
  // data and check widths
  localparam int DATA_W = 32;
  localparam int CHECK_W = 7;
  localparam int CODE_W = 39;
  // default capacity and base of the mapped region
  localparam int unsigned CAP_BYTES = 262144;
  localparam logic [31:0] BASE_ADDR = 32'h4000_0000;
  // transfer sizes on the bus
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // wait-state figures
  localparam logic [1:0] WS_ZERO = 2'h0;
  localparam logic [1:0] WS_ONE = 2'h1;
  localparam logic [1:0] WS_TWO = 2'h2;
  // all-zero and all-one codeword
  localparam logic [38:0] CODE_ZERO = 39'h00_0000_0000;
  localparam logic [38:0] CODE_ONES = 39'h7F_FFFF_FFFF;
  // fixed inversion of the two low stored check bits, so that all-zero or all-one
  // data never forms an all-zero or all-one codeword
  localparam logic [6:0] CHECK_INV = 7'h03;
  // previous-clock operation class
  typedef enum logic [1:0] {
    ESBC_OP_IDLE = 2'b00,
    ESBC_OP_READ = 2'b01,
    ESBC_OP_SUBW = 2'b10,
    ESBC_OP_WORD = 2'b11
  } esbc_op_t;
  // controller states
  typedef enum logic [2:0] {
    ESBC_ST_IDLE = 3'b000,
    ESBC_ST_WAIT = 3'b001,
    ESBC_ST_READ = 3'b010,
    ESBC_ST_MERGE = 3'b011,
    ESBC_ST_DONE = 3'b100
  } esbc_state_t;
  // bus request carrier
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } esbc_req_t;
  // error report carrier
  typedef struct packed {
    logic valid;
    logic uncorr;
    logic [31:0] addr;
    logic [6:0] syndrome;
  } esbc_err_t;
endpackage : esbc_pkg

// File: testbench.sv
// self-checking bench for the ecc sram bus controller
// assumes a 16-word array and the bus master model beside it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  esbc_pkg::esbc_req_t req;
  logic ready;
  logic [31:0] rdata;
  logic bus_err;
  esbc_pkg::esbc_err_t err_rpt;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] mem [16]; // expected array contents
  logic [31:0] q;
  logic be;
  logic ev;
  int n;
  // small depth keeps the fill short
  esbc_ctrl #(.DEPTH(16), .AW(4), .EXTRA_WS(2'h0)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .req(req), .ready(ready),
    .rdata(rdata), .bus_err(bus_err), .err_rpt(err_rpt));
  esbc_bus_master bm (
    .ref_clk(ref_clk), .ready(ready), .rdata(rdata), .bus_err(bus_err),
    .err_rpt(err_rpt), .req(req));
  // 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // one clean in-range access; lat is the expected count, -1 to skip
  task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] off,
                     input logic [31:0] d, input int lat);
    bm.xfer(w, sz, esbc_pkg::BASE_ADDR + off, d, q, be, ev, n);
    if (lat >= 0) check(32'(n), 32'(lat));
    check({31'h0, be | ev}, 32'h0);
  endtask : acc
  // fill every word; first after idle, the rest after a word write
  task automatic t_init();
    for (int i = 0; i < 16; i++) begin
      mem[i] = {16'hC3A5, 8'(i), 8'(~i)};
      acc(1'b1, esbc_pkg::SIZE_WORD, 32'(i * 4), mem[i], 2);
    end
  endtask : t_init
  // read timing against the address of the preceding write
  task automatic t_read();
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h0C, 32'h0, 4);
    check(q, mem[3]);
    mem[5] = 32'h0F1E_2D3C;
    acc(1'b1, esbc_pkg::SIZE_WORD, 32'h14, mem[5], 2);
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h14, 32'h0, 3);
    check(q, mem[5]);
  endtask : t_read
  // sub-word writes merge into the checked word
  task automatic t_subw();
    mem[2][15:8] = 8'h5A;
    acc(1'b1, esbc_pkg::SIZE_BYTE, 32'h09, 32'h0000_5A00, 5);
    mem[7] = 32'h1357_9BDF;
    acc(1'b1, esbc_pkg::SIZE_WORD, 32'h1C, mem[7], 2);
    mem[7][31:16] = 16'hBEEF;
    acc(1'b1, esbc_pkg::SIZE_HALF, 32'h1E, 32'hBEEF_0000, 6);
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h08, 32'h0, 4);
    check(q, mem[2]);
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h1C, 32'h0, -1);
    check(q, mem[7]);
    mem[4][31:24] = 8'h77;
    acc(1'b1, esbc_pkg::SIZE_BYTE, 32'h13, 32'h7700_0000, 5);
  endtask : t_subw
  // accesses outside the region are refused and touch nothing
  task automatic t_range();
    bm.xfer(1'b0, esbc_pkg::SIZE_WORD, esbc_pkg::BASE_ADDR - 32'h4, 32'h0, q, be, ev, n);
    check({31'h0, be}, 32'h1);
    bm.xfer(1'b1, esbc_pkg::SIZE_WORD, esbc_pkg::BASE_ADDR + 32'(esbc_pkg::CAP_BYTES),
            32'hFFFF_0000, q, be, ev, n);
    check({31'h0, be}, 32'h1);
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h00, 32'h0, -1);
    check(q, mem[0]);
  endtask : t_range
  // reset while idle, then reset in the middle of a word write
  task automatic t_reset();
    bm.drop();
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({30'h0, ready, bus_err}, 32'h0);
    arst_n = 1'b1;
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h10, 32'h0, 4);
    check(q, mem[4]);
    bm.put(1'b1, esbc_pkg::SIZE_WORD, esbc_pkg::BASE_ADDR + 32'h24, 32'h1234_5678);
    @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b0;
    bm.drop();
    @(negedge ref_clk);
    arst_n = 1'b1;
    // the interrupted word may hold either value; its neighbours may not
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h20, 32'h0, -1);
    check(q, mem[8]);
    acc(1'b0, esbc_pkg::SIZE_WORD, 32'h28, 32'h0, -1);
    check(q, mem[10]);
  endtask : t_reset
  // verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_init();
    t_read();
    t_subw();
    t_range();
    t_reset();
    give_verdict();
  end
  // watchdog: the tests need well under 500 cycles
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
